// [sysctl_pkg.sv]
// package: constants and types for the system control pin block
//------------------------------------------------------------
//------------------------------------------------------------
package sysctl_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PORT = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_FLAG = 8'h0C;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  // control register fields
  localparam int CTRL_XF = 0;
  localparam int CTRL_GIM = 1;
  localparam int CTRL_MODE = 2;
  localparam logic [2:0] CTRL_RST = 3'h2;
  // port control fields: direction [3:0], output level [7:4]
  localparam int PORT_DIR = 0;
  localparam int PORT_OUT = 4;
  localparam logic [7:0] PORT_RST = 8'h00;
  // mode status fields
  localparam int MODE_MAP = 0;
  localparam int MODE_BOOT = 3;
  // interrupt flag / mask bit positions
  localparam int IRQ_NMI = 0;
  localparam int IRQ_SHR = 1;
  localparam int IRQ_UA = 2;
  localparam int IRQ_UB = 3;
  localparam logic [3:0] MASK_RST = 4'h0;
  // cycles from core reset release to first fetch
  localparam logic [4:0] RST_WAIT_CYC = 5'h10;
  // synchroniser width for pin inputs
  localparam int NSYNC = 15;
  // synchroniser reset: float and interrupt lines high, resets low
  localparam logic [14:0] SYNC_RST = 15'h07C8;

  typedef enum logic [2:0] {
    ST_RESET = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN = 3'b100
  } core_st_t;

  // one driven pin: level and active-low output enable
  typedef struct packed {
    logic o;
    logic oe_n;
  } pin_drv_t;
endpackage : sysctl_pkg

// [pin_sync.sv]
// module: two-stage synchroniser for a vector of pin inputs
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic pclk, // core clock
  input wire logic presetn, // async reset, active low
  input wire logic [W-1:0] d, // raw pin levels
  output logic [W-1:0] q // synchronised levels
);
  logic [W-1:0] meta_r;

  // first stage is read only by the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : pin_sync

// [sysctl_pins.sv]
// module: system control pins with apb register access
`timescale 1ns/100ps
module sysctl_pins (
  input wire logic pclk, // core clock, 10 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic core_reset_n, // core reset pin
  input wire logic pll_reset_n, // pll reset pin
  input wire logic div2_mode, // clock mode pin, pll bypassed
  input wire logic output_float_n, // float request pin
  input wire logic boot_style_strap, // boot method strap
  input wire logic memory_map_strap, // memory map strap
  input wire logic nmi_n, // nonmaskable interrupt pin
  input wire logic shared_hold_irq_pin_n, // hold / interrupt pin
  input wire logic user_irq_a_n, // user interrupt a pin
  input wire logic user_irq_b_n, // user interrupt b pin
  input wire logic branch_test_input_n, // branch test pin
  input wire logic [3:0] general_io_in, // io pin levels
  output logic [3:0] general_io_out, // io pin drive
  output logic [3:0] general_io_oe_n, // io enable, low drives
  output sysctl_pkg::pin_drv_t bus_req_pin, // global_bus_request_n
  output sysctl_pkg::pin_drv_t hold_ack_pin, // hold_acknowledge_n
  output sysctl_pkg::pin_drv_t xf_pin, // external_flag_out
  output logic mem_bus_oe_n, // address/data/strobes enable
  input wire logic gdm_access, // core: global data access
  input wire logic conditional_branch_instr, // core: test
  input wire logic core_idle, // core: idle instruction
  output logic branch_taken, // branch decision
  output logic core_halt, // core halted
  output logic pc_clear, // program counter forced to 0
  output logic fetch_start, // pulse: fetch at address 0
  output logic boot_enhanced, // boot routine selector
  output logic rom_in_program, // rom mapped to program
  output logic pll_reset, // pll reset to pll block
  output logic nmi_trap, // pulse: nmi vector trap
  output logic irq_req, // maskable interrupt to core
  output logic [1:0] irq_vec, // winning interrupt index
  output logic irq // level interrupt output
);
  import sysctl_pkg::*;

  //------------------------------------------------------------
  // pin synchronisers
  //------------------------------------------------------------
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] syn;
  logic rs_n;
  logic pll_n;
  logic d2;
  logic flt_n;
  logic boot_s;
  logic map_s;
  logic nmi_s;
  logic shr_s;
  logic ua_s;
  logic ub_s;
  logic bio_s;
  logic [3:0] gio_s;

  assign raw = {general_io_in, branch_test_input_n, user_irq_b_n,
                user_irq_a_n, shared_hold_irq_pin_n, nmi_n,
                memory_map_strap, boot_style_strap, output_float_n,
                div2_mode, pll_reset_n, core_reset_n};

  // reset idle: pins stay driven, core and pll held in reset
  pin_sync #(.W(NSYNC), .RST_VAL(SYNC_RST)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(raw),
    .q(syn)
  );

  assign {gio_s, bio_s, ub_s, ua_s, shr_s, nmi_s, map_s, boot_s,
          flt_n, d2, pll_n, rs_n} = syn;

  //------------------------------------------------------------
  // registers
  //------------------------------------------------------------
  logic [2:0] ctrl_r;
  logic [7:0] port_r;
  logic [3:0] mode_r;
  logic [3:0] flag_r;
  logic [3:0] mask_r;
  logic hold_r;
  core_st_t st_r;
  logic [4:0] cnt_r;
  logic [3:0] irq_prev_r;
  logic [3:0] irq_now;
  logic [3:0] irq_edge;
  logic wr;
  logic rd_ok;

  // decode shared by write and read paths
  function automatic logic hit(input logic [7:0] a,
                              input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  assign wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign rd_ok = hit(paddr, OFS_CTRL) || hit(paddr, OFS_PORT) ||
                 hit(paddr, OFS_MODE) || hit(paddr, OFS_FLAG) ||
                 hit(paddr, OFS_MASK) || hit(paddr, OFS_STAT);
  assign pslverr = psel && penable && !rd_ok;

  // control: flag level, global mask, shared pin mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r <= CTRL_RST;
    else if (wr && hit(paddr, OFS_CTRL))
      ctrl_r <= pwdata[2:0];
  end

  // port control: io pins come up as inputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      port_r <= PORT_RST;
    else if (!rs_n)
      port_r <= PORT_RST;
    else if (wr && hit(paddr, OFS_PORT))
      port_r <= pwdata[7:0];
  end

  // interrupt mask
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_r <= MASK_RST;
    else if (wr && hit(paddr, OFS_MASK))
      mask_r <= pwdata[3:0];
  end

  // straps latched only while core reset is held
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_r <= 4'h0;
    else if (!rs_n)
    begin
      mode_r[MODE_MAP] <= map_s;
      mode_r[MODE_BOOT] <= boot_s;
    end
  end

  assign boot_enhanced = mode_r[MODE_BOOT];
  assign rom_in_program = !mode_r[MODE_MAP];

  //------------------------------------------------------------
  // interrupt flags: falling pin edges set, write one clears
  //------------------------------------------------------------
  assign irq_now = {ub_s, ua_s, shr_s, nmi_s};
  assign irq_edge = irq_prev_r & ~irq_now;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_prev_r <= 4'hF;
    else
      irq_prev_r <= irq_now;
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_r <= 4'h0;
    else if (!rs_n)
      flag_r <= 4'h0;
    else if (wr && hit(paddr, OFS_FLAG))
      flag_r <= (flag_r & ~pwdata[3:0]) | irq_edge;
    else
      flag_r <= flag_r | irq_edge;
  end

  // nmi bypasses both masks
  assign nmi_trap = irq_edge[IRQ_NMI] && st_r == ST_RUN;

  // user interrupts gated by mask and global mask, a beats b
  always_comb
  begin
    logic [3:0] live;
    live = flag_r & mask_r;
    irq_req = 1'b0;
    irq_vec = 2'd0;
    if (!ctrl_r[CTRL_GIM] && st_r == ST_RUN)
    begin
      if (live[IRQ_SHR])
      begin
        irq_req = 1'b1;
        irq_vec = 2'd1;
      end
      else if (live[IRQ_UA])
      begin
        irq_req = 1'b1;
        irq_vec = 2'd2;
      end
      else if (live[IRQ_UB])
      begin
        irq_req = 1'b1;
        irq_vec = 2'd3;
      end
    end
  end

  // system interrupt line: any unmasked sticky flag
  assign irq = |(flag_r & mask_r);

  //------------------------------------------------------------
  // core reset sequence
  //------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= ST_RESET;
      cnt_r <= 5'h00;
    end
    else if (!rs_n)
    begin
      st_r <= ST_RESET;
      cnt_r <= 5'h00;
    end
    else
    begin
      case (st_r)
        ST_RESET:
        begin
          st_r <= ST_WAIT;
          cnt_r <= 5'h01;
        end
        ST_WAIT:
        begin
          if (cnt_r == RST_WAIT_CYC)
            st_r <= ST_RUN;
          else
            cnt_r <= cnt_r + 5'h01;
        end
        ST_RUN: st_r <= ST_RUN;
        default: st_r <= ST_RESET;
      endcase
    end
  end

  assign core_halt = st_r != ST_RUN;
  assign pc_clear = st_r == ST_RESET;
  assign fetch_start = st_r == ST_WAIT && cnt_r == RST_WAIT_CYC;

  // pll restarts only with the core, never in bypass mode
  assign pll_reset = !pll_n && !rs_n && !d2;

  //------------------------------------------------------------
  // hold and branch test
  //------------------------------------------------------------
  // hold granted only while the core idles in hold mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hold_r <= 1'b0;
    else
      hold_r <= !ctrl_r[CTRL_MODE] && !shr_s && core_idle;
  end

  // branch decision sampled when the core tests the pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      branch_taken <= 1'b0;
    else if (conditional_branch_instr)
      branch_taken <= !bio_s;
  end

  //------------------------------------------------------------
  // pin drivers; float pin overrides everything
  //------------------------------------------------------------
  assign bus_req_pin.o = !(gdm_access && !hold_r);
  assign bus_req_pin.oe_n = !flt_n;
  assign hold_ack_pin.o = !hold_r;
  assign hold_ack_pin.oe_n = !flt_n;
  assign xf_pin.o = ctrl_r[CTRL_XF];
  assign xf_pin.oe_n = !flt_n;
  assign mem_bus_oe_n = hold_r || !flt_n;
  assign general_io_out = port_r[PORT_OUT +: 4];
  assign general_io_oe_n = ~port_r[PORT_DIR +: 4] | {4{!flt_n}};

  //------------------------------------------------------------
  // apb read mux
  //------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      prdata <= 32'h00000000;
      if (hit(paddr, OFS_CTRL))
        prdata[2:0] <= ctrl_r;
      else if (hit(paddr, OFS_PORT))
        prdata[11:0] <= {gio_s, port_r};
      else if (hit(paddr, OFS_MODE))
        prdata[3:0] <= mode_r;
      else if (hit(paddr, OFS_FLAG))
        prdata[3:0] <= flag_r;
      else if (hit(paddr, OFS_MASK))
        prdata[3:0] <= mask_r;
      else if (hit(paddr, OFS_STAT))
        prdata[5:0] <= {hold_r, branch_taken, bio_s, st_r};
    end
  end

  //------------------------------------------------------------
  // assertions
  //------------------------------------------------------------
  property p_bus_req;
    @(posedge pclk) disable iff (!presetn)
      gdm_access && !hold_r |-> !bus_req_pin.o;
  endproperty
  a_bus_req: assert property (p_bus_req)
    else $error("bus request not low on global access");

  property p_hold_float;
    @(posedge pclk) disable iff (!presetn)
      hold_r |-> mem_bus_oe_n && !hold_ack_pin.o;
  endproperty
  a_hold_float: assert property (p_hold_float)
    else $error("hold without float and acknowledge");

  property p_float;
    @(posedge pclk) disable iff (!presetn)
      !flt_n |-> bus_req_pin.oe_n && xf_pin.oe_n &&
                 hold_ack_pin.oe_n && general_io_oe_n == 4'hF;
  endproperty
  a_float: assert property (p_float)
    else $error("pin driven while float requested");

  property p_branch;
    @(posedge pclk) disable iff (!presetn)
      conditional_branch_instr |=> branch_taken == !$past(bio_s);
  endproperty
  a_branch: assert property (p_branch)
    else $error("branch decision does not follow test input");

  property p_wait16;
    @(posedge pclk) disable iff (!presetn)
      $rose(rs_n) |-> core_halt [*8] ##1 core_halt [*8]
                      ##1 (rs_n == 1'b0 || fetch_start);
  endproperty
  a_wait16: assert property (p_wait16)
    else $error("fetch not started 16 cycles after reset");

  property p_halt;
    @(posedge pclk) disable iff (!presetn)
      !rs_n |=> core_halt && pc_clear;
  endproperty
  a_halt: assert property (p_halt)
    else $error("core not halted under reset");

  property p_pll;
    @(posedge pclk) disable iff (!presetn)
      pll_reset |-> !rs_n && !d2;
  endproperty
  a_pll: assert property (p_pll)
    else $error("pll reset outside core reset");

  property p_strap;
    @(posedge pclk) disable iff (!presetn)
      rs_n && $past(rs_n) |-> $stable(mode_r);
  endproperty
  a_strap: assert property (p_strap)
    else $error("mode status changed outside reset");

  property p_nmi;
    @(posedge pclk) disable iff (!presetn)
      st_r == ST_RUN && $fell(nmi_s) |-> nmi_trap;
  endproperty
  a_nmi: assert property (p_nmi)
    else $error("nmi did not trap");

  property p_mask;
    @(posedge pclk) disable iff (!presetn)
      irq_req |-> !ctrl_r[CTRL_GIM] && (flag_r & mask_r) != 4'h0;
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked interrupt reached core");

  property p_flag_set;
    @(posedge pclk) disable iff (!presetn)
      rs_n && irq_edge[IRQ_UA] |=> flag_r[IRQ_UA];
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("user flag lost on edge");

  c_fetch: cover property (@(posedge pclk) disable iff (!presetn)
    fetch_start);
  c_hold: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(hold_r));
  c_irq: cover property (@(posedge pclk) disable iff (!presetn)
    irq_req && irq_vec == 2'd3);
endmodule : sysctl_pins

// [ext_pins_model.sv]
// model: far-side pin drivers with pull-ups on the io lines
`timescale 1ns/100ps
module ext_pins_model (
  input wire logic pclk, // core clock
  input wire logic [3:0] io_out, // io level from block
  input wire logic [3:0] io_oe_n, // io enable, low drives
  output logic [9:0] pins, // raw pin levels, see order below
  output logic [3:0] io_in // resolved io line levels
);
  // -------------------------------------------------------
  // pin drive
  // -------------------------------------------------------
  // order: pll_n core_n test_n float_n map boot b_n a_n sh_n nmi_n
  // both resets start low together at power-up
  initial pins = 10'h0DF;

  // new levels land by nonblocking assignment at a rising edge
  task set_pins(input logic [9:0] v);
    @(posedge pclk);
    pins <= v;
  endtask : set_pins

  // undriven io lines float up through board pull-ups
  always_comb
    for (int i = 0; i < 4; i++)
      io_in[i] = io_oe_n[i] ? 1'b1 : io_out[i];
endmodule : ext_pins_model

// [sysctl_pins_tb.sv]
// testbench: system control pins with apb master and pin model
`timescale 1ns/100ps
module sysctl_pins_tb;
  import sysctl_pkg::*;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic e;
  } row_t;
  // sync 2, one step into wait, then the wait count
  localparam int FETCH_N = 3 + int'(RST_WAIT_CYC);
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, gdm = 1'b0, cbr = 1'b0, idle = 1'b0;
  logic div2 = 1'b0;
  logic [9:0] pins, pv = 10'h0DF;
  logic [3:0] io_in, io_out, io_oe_n;
  logic fetch_start, core_halt, pc_clear, branch_taken, nmi_trap;
  logic irq_req, irq, pll_reset, mem_oe_n, boot_enh, rom_prog;
  logic [1:0] irq_vec;
  pin_drv_t breq, hack, xf;
  int miscompares = 0;
  int total_checks = 0;
  int n;
  row_t rows [6];

  always #50 pclk = ~pclk;

  ext_pins_model model (.pclk(pclk), .io_out(io_out),
    .io_oe_n(io_oe_n), .pins(pins), .io_in(io_in));

  sysctl_pins dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_reset_n(pins[8]),
    .pll_reset_n(pins[9]), .div2_mode(div2),
    .output_float_n(pins[6]), .boot_style_strap(pins[4]),
    .memory_map_strap(pins[5]), .nmi_n(pins[0]),
    .shared_hold_irq_pin_n(pins[1]), .user_irq_a_n(pins[2]),
    .user_irq_b_n(pins[3]), .branch_test_input_n(pins[7]),
    .general_io_in(io_in), .general_io_out(io_out),
    .general_io_oe_n(io_oe_n), .bus_req_pin(breq),
    .hold_ack_pin(hack), .xf_pin(xf), .mem_bus_oe_n(mem_oe_n),
    .gdm_access(gdm), .conditional_branch_instr(cbr),
    .core_idle(idle), .branch_taken(branch_taken),
    .core_halt(core_halt), .pc_clear(pc_clear),
    .fetch_start(fetch_start), .boot_enhanced(boot_enh),
    .rom_in_program(rom_prog), .pll_reset(pll_reset),
    .nmi_trap(nmi_trap), .irq_req(irq_req), .irq_vec(irq_vec),
    .irq(irq));

  // -------------------------------------------------------
  // helpers
  // -------------------------------------------------------
  task check(input string what, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one apb transfer; request held until pready is seen high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task pin(input int i, input logic v);
    pv[i] = v;
    model.set_pins(pv);
  endtask : pin

  // idle cycles, then look at settled outputs
  task cyc(input int k);
    repeat (k) @(posedge pclk);
    @(negedge pclk);
  endtask : cyc

  task end_sim;
    if (miscompares == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  // -------------------------------------------------------
  // sequence
  // -------------------------------------------------------
  initial
  begin
    rows[0] = {OFS_CTRL, 32'h2, 1'b0};
    rows[1] = {OFS_PORT, 32'hF00, 1'b0};
    rows[2] = {OFS_MODE, 32'h8, 1'b0};
    rows[3] = {OFS_FLAG, 32'h0, 1'b0};
    rows[4] = {OFS_STAT, 32'hC, 1'b0};
    rows[5] = {8'h18, 32'h0, 1'b1};
    cyc(0);
    check("rst oe", 32'(io_oe_n), 32'hF);
    check("rst halt", 32'(core_halt & pc_clear), 32'h1);
    check("rst pll", 32'(pll_reset), 32'h1);
    @(posedge pclk);
    presetn <= 1'b1;
    pv[9:8] = 2'b11;
    model.set_pins(pv);
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (fetch_start !== 1'b1 && n < 60);
    check("fetch wait", n, FETCH_N);
    cyc(0);
    check("run", 32'({fetch_start, core_halt, pc_clear}), 32'h0);
    // ordinary register reads, the last one unmapped
    foreach (rows[i])
    begin
      apb(1'b0, rows[i].a, 32'h0);
      check("reg", rd, rows[i].d);
      check("err", 32'(err), 32'(rows[i].e));
    end
    check("maps", 32'({boot_enh, rom_prog}), 32'h3);
    // flag, io outputs, then float
    apb(1'b1, OFS_CTRL, 32'h3);
    apb(1'b1, OFS_PORT, 32'h5F);
    cyc(3);
    check("xf", 32'(xf), 32'h2);
    check("io", 32'({io_out, io_oe_n}), 32'h50);
    apb(1'b0, OFS_PORT, 32'h0);
    check("io rd", rd, 32'h55F);
    pin(6, 1'b0);
    cyc(3);
    check("flt", 32'({io_oe_n, breq.oe_n, hack.oe_n, xf.oe_n}),
      32'h7F);
    pin(6, 1'b1);
    @(posedge pclk);
    gdm <= 1'b1;
    cyc(1);
    check("breq", 32'(breq.o), 32'h0);
    @(posedge pclk);
    gdm <= 1'b0;
    // branch on test pin low, then not on high
    pin(7, 1'b0);
    cyc(3);
    @(posedge pclk);
    cbr <= 1'b1;
    cyc(1);
    check("bt", 32'(branch_taken), 32'h1);
    pin(7, 1'b1);
    cyc(3);
    cyc(1);
    check("bnt", 32'(branch_taken), 32'h0);
    @(posedge pclk);
    cbr <= 1'b0;
    // hold through the shared pin with the core idle
    idle <= 1'b1;
    pin(1, 1'b0);
    cyc(4);
    check("hold", 32'({hack.o, mem_oe_n}), 32'h1);
    @(posedge pclk);
    idle <= 1'b0;
    pin(1, 1'b1);
    apb(1'b1, OFS_FLAG, 32'hF);
    // user interrupts: flag, mask, global mask, priority
    pv[3:2] = 2'b00;
    model.set_pins(pv);
    cyc(4);
    apb(1'b0, OFS_FLAG, 32'h0);
    check("uflag", rd, 32'hC);
    check("irq0", 32'(irq), 32'h0);
    apb(1'b1, OFS_MASK, 32'hC);
    cyc(0);
    check("irq1", 32'({irq, irq_req}), 32'h2);
    apb(1'b1, OFS_CTRL, 32'h1);
    cyc(0);
    check("vec a", 32'({irq_req, irq_vec}), 32'h6);
    apb(1'b1, OFS_FLAG, 32'h4);
    cyc(0);
    check("vec b", 32'({irq_req, irq_vec}), 32'h7);
    apb(1'b1, OFS_MASK, 32'h0);
    cyc(0);
    check("masked", 32'({irq, irq_req}), 32'h0);
    pv[3:2] = 2'b11;
    model.set_pins(pv);
    apb(1'b1, OFS_FLAG, 32'h8);
    apb(1'b0, OFS_FLAG, 32'h0);
    check("clr", rd, 32'h0);
    // nmi with every mask closed
    apb(1'b1, OFS_CTRL, 32'h2);
    pin(0, 1'b0);
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (nmi_trap !== 1'b1 && n < 8);
    check("nmi", 32'(nmi_trap), 32'h1);
    pin(0, 1'b1);
    // shared pin in interrupt mode never grants hold
    apb(1'b1, OFS_CTRL, 32'h6);
    @(posedge pclk);
    idle <= 1'b1;
    pin(1, 1'b0);
    cyc(4);
    check("no hold", 32'({hack.o, mem_oe_n}), 32'h2);
    @(posedge pclk);
    idle <= 1'b0;
    pin(1, 1'b1);
    // core reset mid-run; map strap latched only while in reset
    pv[9:8] = 2'b00;
    pv[5] = 1'b1;
    model.set_pins(pv);
    cyc(4);
    check("rst2", 32'({pc_clear, rom_prog, io_oe_n}), 32'h2F);
    check("pll on", 32'(pll_reset), 32'h1);
    // bypass mode: pll reset ignored while core reset is held
    @(posedge pclk);
    div2 <= 1'b1;
    cyc(3);
    check("pll div2", 32'(pll_reset), 32'h0);
    @(posedge pclk);
    div2 <= 1'b0;
    pv[9:8] = 2'b11;
    model.set_pins(pv);
    cyc(4);
    pin(5, 1'b0);
    cyc(4);
    apb(1'b0, OFS_MODE, 32'h0);
    check("mode", rd, 32'h9);
    apb(1'b0, OFS_FLAG, 32'h0);
    check("flg2", rd, 32'h0);
    end_sim();
  end

  // watchdog, far beyond the fewer than two hundred cycles needed
  initial
  begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    end_sim();
  end
endmodule : sysctl_pins_tb
